// >>> design/emcc_pkg.sv
// Purpose: constants for the external memory channel config block
// Assumes: 32-bit register port, 100 MHz system clock
// Notes:   channel registers sit one word apart from offset zero
package emcc_pkg;
   localparam int          NUM_CH         = 3;
   localparam logic [7:0]  OFS_CH2_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_CH3_CTRL   = 8'h04;
   localparam logic [7:0]  OFS_CH4_CTRL   = 8'h08;
   localparam logic [7:0]  OFS_STEP       = 8'h04;
   localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
   localparam logic [31:0] CTRL_WR_MASK   = 32'hFFFF_FFAF;
   localparam int          POS_BASE       = 20;
   localparam int          POS_PAGE       = 18;
   localparam int          POS_PWAIT      = 16;
   localparam int          POS_NWAIT      = 12;
   localparam int          POS_SPAN       = 8;
   localparam int          POS_WIDTH      = 7;
   localparam int          POS_BEPOL      = 5;
   localparam int          POS_EN         = 3;
   localparam int          POS_SH         = 0;
   localparam logic [3:0]  SPAN_MAX       = 4'hA;
   localparam logic [5:0]  WAIT_EXT_ACK   = 6'h3F;
   localparam logic [1:0]  PAGE_OFF       = 2'h0;
   localparam logic [4:0]  PAGE_W1        = 5'h04;
   localparam logic [4:0]  PAGE_W2        = 5'h08;
   localparam logic [4:0]  PAGE_W3        = 5'h10;
   localparam logic [31:0] WORD_STEP      = 32'h0000_0004;
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_SETUP  = 4'b0010,
      ST_STROBE = 4'b0100,
      ST_HOLD   = 4'b1000
   } emcc_state_t;
endpackage : emcc_pkg

// >>> design/emcc_top.sv
// Purpose: control registers and access sequencer for memory channels
// Assumes: one request at a time; burst length 1 to 16 words
// Notes:   data path lives outside; this drives strobes and address
`timescale 1ns/1ns
module emcc_top
   import emcc_pkg::*;
(
   input  wire logic                  i_clk,
   input  wire logic                  i_arst_n,
   input  wire logic [7:0]            i_reg_addr,
   input  wire logic [31:0]           i_reg_wdata,
   input  wire logic                  i_reg_wr,
   input  wire logic                  i_reg_rd,
   output      logic [31:0]           o_reg_rdata,
   input  wire logic                  i_req,
   input  wire logic [31:0]           i_addr,
   input  wire logic                  i_we,
   input  wire logic [3:0]            i_be,
   input  wire logic [4:0]            i_burst_len,
   output      logic                  o_ready,
   output      logic                  o_word_done,
   output      logic                  o_miss,
   output      logic [31:0]           o_ext_addr,
   output      logic [emcc_pkg::NUM_CH-1:0] o_ce_n,
   output      logic                  o_oe_n,
   output      logic                  o_we_n,
   output      logic [3:0]            o_byte_lane_strobes_n,
   input  wire logic                  i_ack_n,
   output      logic                  o_ack_n,
   output      logic                  o_ack_oe
);
   import emcc_pkg::*;

   logic [31:0]         cfg_ff [NUM_CH];
   logic [NUM_CH-1:0]   hit;
   logic [31:0]         sel_cfg;
   logic [1:0]          sel_ch;
   emcc_state_t         state_ff, nxt_state;
   logic [31:0]         cur_ff, nxt_cur;
   logic [1:0]          ch_ff, nxt_ch;
   logic [31:0]         addr_ff, nxt_addr;
   logic                we_ff, nxt_we;
   logic [3:0]          be_ff, nxt_be;
   logic [4:0]          len_ff, nxt_len;
   logic [4:0]          word_ff, nxt_word;
   logic                half_ff, nxt_half;
   logic                two_ff, nxt_two;
   logic [5:0]          wait_ff;
   logic [2:0]          sh_ff;
   logic                ack_meta_ff, ack_sync_ff;
   logic                miss_ff;
   logic [31:0]         rdata_ff;
   logic                ext, n_ext, st_done, adv, last_half;
   logic [5:0]          n_wait;
   logic [4:0]          n_pw;
   logic                n_two;

   ////////////////////////////////////////////////////////////////////
   // control registers and channel decode
   generate
      for (genvar i = 0; i < NUM_CH; i++)
      begin : g_ch
         logic [31:0] ofs;
         logic [11:0] msk;
         logic [3:0]  span;
         assign ofs  = 32'(OFS_CH2_CTRL) + 32'(i) * 32'(OFS_STEP);
         assign span = cfg_ff[i][POS_SPAN +: 4];
         assign msk  = ~((12'h001 << span) - 12'h001);
         always_ff @(posedge i_clk or negedge i_arst_n)
         begin
            if (!i_arst_n)
               cfg_ff[i] <= CTRL_RST;
            else if (i_reg_wr && i_reg_addr == ofs[7:0])
               cfg_ff[i] <= i_reg_wdata & CTRL_WR_MASK;
         end
         assign hit[i] = cfg_ff[i][POS_EN] && span <= SPAN_MAX
            && (((i_addr[31:20] ^ cfg_ff[i][POS_BASE +: 12]) & msk)
                == 12'h000);
      end
   endgenerate

   always_comb
   begin
      sel_cfg = cfg_ff[0];
      sel_ch  = 2'h0;
      for (int k = NUM_CH - 1; k >= 0; k--)
      begin
         if (hit[k])
         begin
            sel_cfg = cfg_ff[k];
            sel_ch  = 2'(k);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         rdata_ff <= 32'h0000_0000;
      else if (i_reg_rd && i_reg_addr == OFS_CH2_CTRL)
         rdata_ff <= cfg_ff[0];
      else if (i_reg_rd && i_reg_addr == OFS_CH3_CTRL)
         rdata_ff <= cfg_ff[1];
      else if (i_reg_rd && i_reg_addr == OFS_CH4_CTRL)
         rdata_ff <= cfg_ff[2];
      else
         rdata_ff <= 32'h0000_0000;
   end
   assign o_reg_rdata = rdata_ff;

   ////////////////////////////////////////////////////////////////////
   // acknowledge synchroniser
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         ack_meta_ff <= 1'b1;
         ack_sync_ff <= 1'b1;
      end
      else
      begin
         ack_meta_ff <= i_ack_n;
         ack_sync_ff <= ack_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sequencer
   assign ext = cur_ff[POS_PAGE +: 2] == PAGE_OFF
      && cur_ff[POS_NWAIT +: 6] == WAIT_EXT_ACK;
   assign n_ext = nxt_cur[POS_PAGE +: 2] == PAGE_OFF
      && nxt_cur[POS_NWAIT +: 6] == WAIT_EXT_ACK;
   assign st_done = ext ? !ack_sync_ff : wait_ff == 6'h00;
   assign last_half = !two_ff || half_ff;
   assign adv = (state_ff == ST_STROBE && st_done
                 && cur_ff[POS_SH +: 3] == 3'h0)
             || (state_ff == ST_HOLD && sh_ff == 3'h1);
   assign n_two = sel_cfg[POS_WIDTH] && (i_burst_len != 5'h01
      || (i_be[3:2] != 2'h0 && i_be[1:0] != 2'h0));

   always_comb
   begin
      case (nxt_cur[POS_PAGE +: 2])
         2'h1:    n_pw = PAGE_W1;
         2'h2:    n_pw = PAGE_W2;
         default: n_pw = PAGE_W3;
      endcase
      if (nxt_cur[POS_PAGE +: 2] == PAGE_OFF)
         n_wait = nxt_cur[POS_NWAIT +: 6];
      else if (((nxt_word & (n_pw - 5'h01)) == 5'h00)
               && !(nxt_two && nxt_half))
         n_wait = {2'h0, nxt_cur[POS_NWAIT +: 4]};
      else
         n_wait = {4'h0, nxt_cur[POS_PWAIT +: 2]};
   end

   always_comb
   begin
      nxt_state = state_ff;
      nxt_cur   = cur_ff;
      nxt_ch    = ch_ff;
      nxt_addr  = addr_ff;
      nxt_we    = we_ff;
      nxt_be    = be_ff;
      nxt_len   = len_ff;
      nxt_word  = word_ff;
      nxt_half  = half_ff;
      nxt_two   = two_ff;
      case (state_ff)
         ST_IDLE:
         begin
            if (i_req && hit != '0)
            begin
               nxt_cur   = sel_cfg;
               nxt_ch    = sel_ch;
               nxt_addr  = i_addr;
               nxt_we    = i_we;
               nxt_be    = i_be;
               nxt_len   = i_burst_len;
               nxt_word  = 5'h00;
               nxt_two   = n_two;
               nxt_half  = !n_two && i_be[1:0] == 2'h0;
               nxt_state = sel_cfg[POS_SH +: 3] != 3'h0
                         ? ST_SETUP : ST_STROBE;
            end
         end
         ST_SETUP:
         begin
            if (sh_ff == 3'h1)
               nxt_state = ST_STROBE;
         end
         ST_STROBE:
         begin
            if (st_done && cur_ff[POS_SH +: 3] != 3'h0)
               nxt_state = ST_HOLD;
         end
         ST_HOLD: ;
         default:
            nxt_state = ST_IDLE;
      endcase
      if (adv)
      begin
         nxt_state = cur_ff[POS_SH +: 3] != 3'h0 ? ST_SETUP : ST_STROBE;
         if (!last_half)
            nxt_half = 1'b1;
         else if (word_ff + 5'h01 < len_ff)
         begin
            nxt_word = word_ff + 5'h01;
            nxt_addr = addr_ff + WORD_STEP;
            nxt_half = 1'b0;
         end
         else
            nxt_state = ST_IDLE;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         state_ff <= ST_IDLE;
         cur_ff   <= CTRL_RST;
         ch_ff    <= 2'h0;
         addr_ff  <= 32'h0000_0000;
         we_ff    <= 1'b0;
         be_ff    <= 4'h0;
         len_ff   <= 5'h01;
         word_ff  <= 5'h00;
         half_ff  <= 1'b0;
         two_ff   <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         cur_ff   <= nxt_cur;
         ch_ff    <= nxt_ch;
         addr_ff  <= nxt_addr;
         we_ff    <= nxt_we;
         be_ff    <= nxt_be;
         len_ff   <= nxt_len;
         word_ff  <= nxt_word;
         half_ff  <= nxt_half;
         two_ff   <= nxt_two;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         wait_ff <= 6'h00;
      else if (nxt_state == ST_STROBE
               && (state_ff != ST_STROBE || adv))
         wait_ff <= n_ext ? 6'h00 : n_wait;
      else if (state_ff == ST_STROBE && wait_ff != 6'h00)
         wait_ff <= wait_ff - 6'h01;
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         sh_ff <= 3'h0;
      else if ((nxt_state == ST_SETUP || nxt_state == ST_HOLD)
               && (nxt_state != state_ff || adv))
         sh_ff <= nxt_cur[POS_SH +: 3];
      else if (sh_ff != 3'h0)
         sh_ff <= sh_ff - 3'h1;
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         miss_ff <= 1'b0;
      else
         miss_ff <= state_ff == ST_IDLE && i_req && hit == '0;
   end

   ////////////////////////////////////////////////////////////////////
   // external pins
   logic strobe;
   assign strobe      = state_ff == ST_STROBE;
   assign o_ready     = state_ff == ST_IDLE;
   assign o_word_done = adv && last_half;
   assign o_miss      = miss_ff;
   assign o_ext_addr  = cur_ff[POS_WIDTH]
                      ? {addr_ff[31:2], half_ff, 1'b0}
                      : {addr_ff[31:2], 2'h0};
   always_comb
   begin
      o_ce_n = '1;
      if (state_ff != ST_IDLE)
         o_ce_n[ch_ff] = 1'b0;
   end
   assign o_oe_n = !(strobe && !we_ff);
   assign o_we_n = !(strobe && we_ff);
   assign o_byte_lane_strobes_n =
      (strobe && (we_ff || !cur_ff[POS_BEPOL])) ? ~be_ff : 4'hF;
   assign o_ack_oe = state_ff != ST_IDLE && !ext;
   assign o_ack_n  = !(strobe && st_done && !ext);

   ////////////////////////////////////////////////////////////////////
   // checks
   logic [6:0] str_len_ff;
   logic [5:0] ld_wait_ff;
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         str_len_ff <= 7'h00;
         ld_wait_ff <= 6'h00;
      end
      else
      begin
         str_len_ff <= strobe && !adv && nxt_state == ST_STROBE
                     ? str_len_ff + 7'h01 : 7'h01;
         if (nxt_state == ST_STROBE && (state_ff != ST_STROBE || adv))
            ld_wait_ff <= n_wait;
      end
   end

   AST_CFG_WR: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      i_reg_wr && i_reg_addr == OFS_CH3_CTRL
      |=> cfg_ff[1] == ($past(i_reg_wdata) & CTRL_WR_MASK))
      else $error("channel register write lost");
   AST_RD_NEXT: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      i_reg_rd && i_reg_addr == OFS_CH4_CTRL |=> o_reg_rdata == cfg_ff[2])
      else $error("register read wrong");
   AST_MISS: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      o_ready && i_req && hit == '0 |=> o_miss && o_ready)
      else $error("miss not flagged");
   AST_RSVD_SPAN: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      cfg_ff[0][POS_SPAN +: 4] > SPAN_MAX |-> !hit[0])
      else $error("reserved span responded");
   AST_EXT_IN: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      strobe && ext |-> !o_ack_oe)
      else $error("ack pin driven in ext mode");
   AST_EXT_WAIT: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      strobe && ext && ack_sync_ff |=> strobe)
      else $error("ext cycle ended without ack");
   AST_WAIT_LEN: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      strobe && !ext && st_done |-> str_len_ff == 7'(ld_wait_ff) + 7'h01)
      else $error("strobe length wrong");
   AST_PAGE_FIRST: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      $rose(strobe) && cur_ff[POS_PAGE +: 2] != PAGE_OFF
      && word_ff == 5'h00 && !half_ff
      |-> wait_ff == {2'h0, cur_ff[POS_NWAIT +: 4]})
      else $error("first page access wait wrong");
   AST_BE_READ: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      strobe && !we_ff && cur_ff[POS_BEPOL] |-> o_byte_lane_strobes_n == 4'hF)
      else $error("byte strobes on read");
   AST_SETUP: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      state_ff == ST_SETUP && sh_ff == 3'h1 |=> strobe)
      else $error("setup not followed by strobe");
   AST_HALVES: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      o_word_done && cur_ff[POS_WIDTH] && len_ff != 5'h01 |-> half_ff)
      else $error("16-bit burst word not split");

   COV_EXT: cover property (@(posedge i_clk) disable iff (!i_arst_n)
      strobe && ext && !ack_sync_ff);
   COV_PAGE: cover property (@(posedge i_clk) disable iff (!i_arst_n)
      o_word_done && cur_ff[POS_PAGE +: 2] != PAGE_OFF && word_ff == 5'h05);
   COV_HALF: cover property (@(posedge i_clk) disable iff (!i_arst_n)
      o_word_done && two_ff);
   COV_SH: cover property (@(posedge i_clk) disable iff (!i_arst_n)
      state_ff == ST_HOLD);
endmodule : emcc_top

// >>> sim/emcc_mem_model.sv
// Purpose: stand-in for a slow external device on any channel
// Assumes: acknowledge line has a pull-up when nobody drives it
// Notes:   pulls acknowledge low i_dly cycles into a strobe
`timescale 1ns/1ns
module emcc_mem_model
(
   input  wire logic       i_clk,
   input  wire logic [2:0] i_ce_n,
   input  wire logic       i_oe_n,
   input  wire logic       i_we_n,
   input  wire logic       i_ext,
   input  wire logic [7:0] i_dly,
   output      logic       o_ack_n,
   output      logic       o_ack_oe
);
   logic [7:0] cnt_ff;
   logic       strb;
   assign strb = ~&i_ce_n & ~(i_oe_n & i_we_n);
   always_ff @(posedge i_clk)
   begin
      cnt_ff <= strb ? cnt_ff + 8'h01 : 8'h00;
   end
   // drives only while selected and strobed, then lets go
   assign o_ack_oe = i_ext & strb & (cnt_ff >= i_dly);
   assign o_ack_n  = ~o_ack_oe;
endmodule : emcc_mem_model

// >>> sim/test_emcc_top.sv
// Purpose: self-checking bench for the memory channel block
// Assumes: channel 2 base 0x100 unless a scenario says otherwise
// Notes:   strobe and wait figures counted at the pins
`timescale 1ns/1ns
module test_emcc_top;
   import emcc_pkg::*;
   localparam int SB = 0, CE = 1, BE = 2, AO = 3, AL = 4, MS = 5, WE = 6;
   logic        i_clk, i_arst_n, i_reg_wr, i_reg_rd, i_req, i_we;
   logic [7:0]  i_reg_addr, dly;
   logic [31:0] i_reg_wdata, i_addr, o_reg_rdata, o_ext_addr, ea;
   logic [3:0]  i_be, o_bls_n, bl_seen;
   logic [4:0]  i_burst_len;
   logic [2:0]  o_ce_n, ce_seen;
   logic        o_ready, o_word_done, o_miss, o_oe_n, o_we_n, ext;
   logic        o_ack_n, o_ack_oe, m_ack_n, m_ack_oe, ack_pin;
   int          fail_count, total_checks, cyc, t;
   int          cnt[7];
   int          dq[$];
   assign ack_pin = o_ack_oe ? o_ack_n : (m_ack_oe ? m_ack_n : 1'b1);
   emcc_top u_emcc_top (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_req(i_req),
      .i_addr(i_addr), .i_we(i_we), .i_be(i_be),
      .i_burst_len(i_burst_len), .o_ready(o_ready),
      .o_word_done(o_word_done), .o_miss(o_miss),
      .o_ext_addr(o_ext_addr), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n),
      .o_we_n(o_we_n), .o_byte_lane_strobes_n(o_bls_n),
      .i_ack_n(ack_pin), .o_ack_n(o_ack_n), .o_ack_oe(o_ack_oe));
   emcc_mem_model u_emcc_mem_model (
      .i_clk(i_clk), .i_ce_n(o_ce_n), .i_oe_n(o_oe_n),
      .i_we_n(o_we_n), .i_ext(ext), .i_dly(dly),
      .o_ack_n(m_ack_n), .o_ack_oe(m_ack_oe));
   ////////////////////////////////////////////////////////////////////
   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      if (o_oe_n === 1'b0 || o_we_n === 1'b0)
      begin
         cnt[SB]++;
         ea = o_ext_addr;
      end
      if (o_we_n === 1'b0)
         cnt[WE]++;
      if (o_ce_n !== 3'h7)
         cnt[CE]++;
      if (o_bls_n !== 4'hF)
         cnt[BE]++;
      if (o_ack_oe === 1'b1)
         cnt[AO]++;
      if (o_ack_oe === 1'b1 && o_ack_n === 1'b0)
         cnt[AL]++;
      if (o_miss === 1'b1)
         cnt[MS]++;
      if (o_word_done === 1'b1)
         dq.push_back(cyc);
      ce_seen = ce_seen | ~o_ce_n;
      bl_seen = bl_seen | ~o_bls_n;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] s, e);
      total_checks++;
      if (s !== e)
      begin
         fail_count++;
         $display("[ERR] %s exp=%h seen=%h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      i_reg_wr    <= 1'b1;
      @(posedge i_clk);
      i_reg_wr    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_reg_addr <= a;
      i_reg_rd   <= 1'b1;
      @(posedge i_clk);
      i_reg_rd   <= 1'b0;
      @(posedge i_clk);
      d = o_reg_rdata;
   endtask : rd
   function automatic logic [31:0] cfg(input logic [1:0] pg, pw,
      input logic [3:0] nw, sp, input logic wd, bp, input logic [2:0] sh);
      return {12'h100, pg, pw, nw, sp, wd, 1'b0, bp, 1'b0, 1'b1, sh};
   endfunction : cfg
   task automatic acc(input logic [31:0] a, input logic w,
      input logic [3:0] be, input logic [4:0] n);
      @(posedge i_clk);
      cnt = '{default: 0};
      dq.delete();
      ce_seen = 3'h0;
      bl_seen = 4'h0;
      i_addr      <= a;
      i_we        <= w;
      i_be        <= be;
      i_burst_len <= n;
      i_req       <= 1'b1;
      @(posedge i_clk);
      t = cyc;
      i_req <= 1'b0;
      for (int k = 0; k < 300; k++)
      begin
         @(posedge i_clk);
         if (o_ready === 1'b1)
            break;
      end
      #1;
      chk("ready", o_ready, 1'b1);
   endtask : acc
   ////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      logic [31:0] d;
      for (int c = 0; c < 3; c++)
      begin
         rd(8'(c * 4), d);
         chk("reset", d, 32'h0000_0000);
         wr(8'(c * 4), 32'hFFFF_FFFF);
         rd(8'(c * 4), d);
         chk("mask", d, 32'hFFFF_FFAF);
         wr(8'(c * 4), 32'h0000_0000);
      end
      wr(8'h0C, 32'hFFFF_FFFF);
      rd(8'h0C, d);
      chk("unmapped", d, 32'h0000_0000);
   endtask : t_regs
   task automatic t_span;
      for (int k = 0; k < 11; k++)
      begin
         wr(8'h04, {12'h000, 8'h00, 4'(k), 8'h08});
         acc((32'h1 << (20 + k)) - 32'h4, 1'b0, 4'hF, 5'h01);
         chk("hit", cnt[MS], 0);
         chk("ce_sel", {29'h0, ce_seen}, 32'h2);
         acc(32'h1 << (20 + k), 1'b0, 4'hF, 5'h01);
         chk("miss", cnt[MS], 1);
      end
      wr(8'h04, 32'h0000_0000);
      acc(32'h0000_0000, 1'b0, 4'hF, 5'h01);
      chk("off", cnt[MS], 1);
   endtask : t_span
   task automatic t_wait;
      logic [5:0] ws[4] = '{6'h00, 6'h01, 6'h23, 6'h3E};
      foreach (ws[i])
      begin
         wr(8'h00, cfg(2'h0, ws[i][5:4], ws[i][3:0], 4'h0, 0, 0, 3'h0));
         acc(32'h1000_0000, 1'b0, 4'hF, 5'h01);
         chk("strobe", cnt[SB], ws[i] + 1);
         chk("done", dq[0] - t, ws[i] + 1);
         chk("ack_lo", cnt[AL], 1);
         chk("ack_oe", cnt[AO] > 0, 1);
         chk("addr32", ea, 32'h1000_0000);
      end
   endtask : t_wait
   task automatic t_bytes;
      for (int b = 0; b < 4; b++)
      begin
         wr(8'h00, cfg(2'h0, 2'h0, 4'h0, 4'h0, 0, b[1], 3'h0));
         acc(32'h1000_0000, b[0], 4'h5, 5'h01);
         chk("be_cyc", cnt[BE], (b == 2) ? 0 : 1);
         chk("be_val", bl_seen, (b == 2) ? 4'h0 : 4'h5);
      end
   endtask : t_bytes
   task automatic t_ext;
      wr(8'h00, cfg(2'h0, 2'h3, 4'hF, 4'h0, 0, 0, 3'h0));
      ext <= 1'b1;
      dly <= 8'h05;
      for (int w = 0; w < 2; w++)
      begin
         acc(32'h1000_0000, w[0], 4'hF, 5'h01);
         chk("ext_oe", cnt[AO], 0);
         chk("ext_len", cnt[SB] >= 7 && cnt[SB] <= 10, 1);
      end
      ext <= 1'b0;
   endtask : t_ext
   task automatic t_page;
      for (int p = 1; p < 4; p++)
      begin
         wr(8'h00, cfg(2'(p), 2'h1, 4'h2, 4'h0, 0, 0, 3'h0));
         acc(32'h1000_0000, 1'b0, 4'hF, 5'h10);
         chk("words", dq.size(), 16);
         for (int i = 0; i < 16; i++)
            chk("gap", dq[i] - (i ? dq[i-1] : t),
                (i % (2 << p)) ? 2 : 3);
      end
   endtask : t_page
   task automatic t_sh;
      for (int s = 1; s < 8; s += 6)
      begin
         // single access, page off: no bursts with setup/hold
         wr(8'h00, cfg(2'h0, 2'h0, 4'h1, 4'h0, 0, 0, 3'(s)));
         acc(32'h1000_0000, 1'b1, 4'hF, 5'h01);
         chk("sh_ce", cnt[CE], 2 * s + 2);
         chk("sh_strb", cnt[SB], 2);
         chk("sh_done", dq[0] - t, 2 * s + 2);
         chk("sh_we", cnt[WE], 2);
      end
   endtask : t_sh
   task automatic t_half;
      logic [3:0] bl[4] = '{4'h3, 4'h6, 4'hC, 4'hF};
      int         ex[4] = '{2, 4, 2, 8};
      logic [3:0] ax[4] = '{4'h0, 4'h2, 4'h2, 4'h6};
      wr(8'h00, cfg(2'h0, 2'h0, 4'h1, 4'h9, 1, 0, 3'h0));
      foreach (bl[i])
      begin
         acc(32'h1000_0000, 1'b0, bl[i], (i == 3) ? 5'h02 : 5'h01);
         chk("half", cnt[SB], ex[i]);
         chk("half_addr", ea, {28'h1000_000, ax[i]});
      end
   endtask : t_half
   ////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks=%0d errors=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   initial
   begin
      repeat (20000) @(posedge i_clk);
      fail_count++;
      summarize;
   end
   initial
   begin
      {i_arst_n, i_reg_wr, i_reg_rd, i_req, i_we, ext} = '0;
      {i_reg_addr, dly, i_reg_wdata, i_addr, i_be, i_burst_len} = '0;
      repeat (12) @(posedge i_clk);
      i_arst_n <= 1'b1;
      t_regs;
      t_span;
      t_wait;
      t_bytes;
      t_ext;
      t_page;
      t_sh;
      t_half;
      summarize;
   end
endmodule : test_emcc_top
